// [rtl/mtop_pkg.sv]
/*
 Shared constants, types and register map of the motor thermal overload
 block. Assumes a single 250 MHz clock domain.
*/
package mtop_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ        = 250_000_000;
   localparam int unsigned TICK_US       = 1000;
   localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned BLINK_MS      = 500;
   localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * BLINK_MS;
   localparam int unsigned TICKS_PER_SEC = 1_000_000 / TICK_US;

   // Thermal model
   localparam logic [31:0] THERM_FULL    = 32'h4000_0000;
   localparam int unsigned THERM_SHIFT   = 30;
   localparam int unsigned TRIP_MULT_SQ  = 36;
   localparam logic [31:0] THERM_GAIN    =
      32'(THERM_FULL / (TRIP_MULT_SQ * TICKS_PER_SEC));
   localparam int unsigned COOL_SHIFT    = 12;
   localparam logic [7:0]  PCT_FULL      = 8'h64;
   localparam logic [4:0]  CLASS_MIN     = 5'h05;
   localparam logic [7:0]  CTS_INIT      = 8'h28;

   // Register offsets
   localparam logic [7:0]  ADDR_FLA      = 8'h00;
   localparam logic [7:0]  ADDR_SF       = 8'h04;
   localparam logic [7:0]  ADDR_CLS_ST   = 8'h08;
   localparam logic [7:0]  ADDR_CLS_RUN  = 8'h0c;
   localparam logic [7:0]  ADDR_MODE     = 8'h10;
   localparam logic [7:0]  ADDR_STATUS   = 8'h14;
   localparam logic [7:0]  ADDR_PCT      = 8'h18;
   localparam logic [7:0]  ADDR_CTS      = 8'h1c;

   // Reset values
   localparam logic [15:0] RST_FLA       = 16'h0000;
   localparam logic [7:0]  RST_SF        = 8'h64;
   localparam logic [4:0]  RST_CLASS     = 5'h0a;

   // Status register bit positions
   localparam int unsigned ST_TRIP_BIT   = 0;
   localparam int unsigned ST_RSTOK_BIT  = 1;
   localparam int unsigned ST_MISSING_FULL_LOAD_INDICATION_BIT   = 2;
   localparam int unsigned ST_INH_BIT    = 3;
   localparam int unsigned ST_RUN_BIT    = 4;
   localparam int unsigned ST_SPEED_BIT  = 5;

   // Display
   localparam logic [2:0]  SCREEN_LAST   = 3'h5;
   localparam logic [2:0]  SCREEN_THERM  = 3'h4;
   localparam logic [7:0]  LETTER_H      = 8'h48;
   localparam logic [7:0]  LETTER_NONE   = 8'h20;

   typedef enum logic [1:0] {
      MODE_MANUAL = 2'h0,
      MODE_AUTO   = 2'h1,
      MODE_OFF    = 2'h2
   } mtop_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_RUN   = 3'b010,
      ST_MISSING_FULL_LOAD_INDICATION  = 3'b100
   } mtop_state_t;

   typedef struct packed {
      logic [15:0] fla;
      logic [7:0]  sf;
      logic [4:0]  cls_start;
      logic [4:0]  cls_run;
      logic [1:0]  mode;
   } mtop_cfg_t;

   typedef struct packed {
      logic [7:0] letter;
      logic [3:0] d2;
      logic [3:0] d1;
      logic [3:0] d0;
   } mtop_disp_t;

endpackage

// [rtl/mtop_avg3.sv]
/*
 Running average of the capacity used by the last three successful
 starts. Assumes pushes come from logic on the same clock.
*/
`timescale 1ns/10ps
module mtop_avg3 (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       push_i,
   input  wire logic [7:0] val_i,
   output logic      [7:0] avg_o
);
   logic [7:0] ent_reg [3];
   logic [9:0] sum;

   assign sum = {2'h0, ent_reg[0]} + {2'h0, ent_reg[1]} +
                {2'h0, ent_reg[2]};

   // Shift history in on each successful start
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ent_reg[0] <= mtop_pkg::CTS_INIT;
         ent_reg[1] <= mtop_pkg::CTS_INIT;
         ent_reg[2] <= mtop_pkg::CTS_INIT;
      end else if (push_i) begin
         ent_reg[0] <= val_i;
         ent_reg[1] <= ent_reg[0];
         ent_reg[2] <= ent_reg[1];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         avg_o <= mtop_pkg::CTS_INIT;
      end else begin
         avg_o <= 8'(sum / 10'h003);
      end
   end
endmodule

// [rtl/mtop_overload.sv]
/*
 I2t thermal overload protection for a soft-started motor: thermal
 register, trip and reset handling, start interlock, status screens and
 software settings port. Assumes keys and run command arrive from pins,
 current and at-speed from logic on the same clock, and an outside store
 that saves and restores the thermal register across power loss.
*/
// The placing of the registers and the address-and-strobe port are this design's own decisions.
// Function
// - Model heating as accumulated current squared
// - Thermal register saved and restored externally
// - Capacity shown as percent, full is 100
// - Capacity drops as the motor heats
// - Capacity from FLA, service factor, classes
// - Fourth screen up shows H and percent
// - Status screens wrap in both directions
// - FLA resets to zero; zero blocks running
// - Start without FLA gives missing-FLA fault
// - Mode setting can disable overload protection
// - Manual reset default; needs reset key
// - Trip clears only after enough cooling, except in off mode, which clears it at once
// - Held reset key never blocks trip
// - LED solid when tripped, flashing when resettable
// - Auto mode clears trip itself after cooling
// - Reset needs average of last three starts
// - Early reset shows inhibit, trip stays
// - Class is seconds to trip at 600%
// - At-speed switches start class to run class
`timescale 1ns/10ps
module mtop_overload #(
   parameter int unsigned TICK_CYC  = mtop_pkg::TICK_CYC,
   parameter int unsigned BLINK_CYC = mtop_pkg::BLINK_CYC
) (
   input  wire logic        CLOCK_I,
   input  wire logic        SRST_I,
   input  wire logic [7:0]  REG_ADDR_I,
   input  wire logic [31:0] REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output logic      [31:0] REG_RDATA_O,
   input  wire logic [15:0] MOTOR_CURRENT_I,
   input  wire logic        AT_SPEED_I,
   input  wire logic        KEY_UP_I,
   input  wire logic        KEY_DOWN_I,
   input  wire logic        KEY_RESET_I,
   input  wire logic        RUN_CMD_I,
   input  wire logic        NV_RESTORE_I,
   input  wire logic [31:0] NV_VALUE_I,
   output logic      [31:0] NV_VALUE_O,
   output logic             NV_STORE_O,
   output logic             FIRE_EN_O,
   output logic             OL_TRIP_O,
   output logic             OL_LED_O,
   output logic             MISSING_FULL_LOAD_INDICATION_FAULT_O,
   output logic             RESET_INHIBIT_O,
   output logic      [2:0]  SCREEN_O,
   output mtop_pkg::mtop_disp_t DISP_O
);
   localparam int unsigned NPIN = 4;
   localparam int unsigned P_UP = 0;
   localparam int unsigned P_DN = 1;
   localparam int unsigned P_RS = 2;
   localparam int unsigned P_RUN = 3;

   // Pin synchronisers
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_reg;
   logic [NPIN-1:0] pin_d_reg;
   logic [NPIN-1:0] pin_rise;

   assign pin_raw = {RUN_CMD_I, KEY_RESET_I, KEY_DOWN_I, KEY_UP_I};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_sync
         logic [2:0] sh_reg;
         always_ff @(posedge CLOCK_I) begin
            if (SRST_I) begin
               sh_reg       <= 3'h0;
               pin_reg[gi]  <= 1'b0;
               pin_d_reg[gi] <= 1'b0;
            end else begin
               sh_reg       <= {sh_reg[1:0], pin_raw[gi]};
               if (sh_reg[1] == sh_reg[2]) begin
                  pin_reg[gi] <= sh_reg[2];
               end
               pin_d_reg[gi] <= pin_reg[gi];
            end
         end
         assign pin_rise[gi] = pin_reg[gi] & ~pin_d_reg[gi];
      end
   endgenerate

   wire reset_edge = pin_rise[P_RS];
   wire run_rise   = pin_rise[P_RUN];

   // Settings
   mtop_pkg::mtop_cfg_t cfg_reg;
   mtop_pkg::mtop_state_t state_reg;
   mtop_pkg::mtop_state_t state_next;

   wire fla_zero  = (cfg_reg.fla == 16'h0000);
   wire mode_off  = (cfg_reg.mode == mtop_pkg::MODE_OFF);
   wire mode_auto = (cfg_reg.mode == mtop_pkg::MODE_AUTO);
   wire mode_man  = ~mode_off & ~mode_auto;

   // Periodic update tick
   logic [31:0] tick_cnt_reg;
   wire tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         tick_cnt_reg <= 32'h0;
      end else begin
         tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      end
   end

   // Thermal model
   logic [31:0] acc_reg;
   logic [31:0] acc_next;
   logic        at_speed_reg;
   wire  [4:0]  cls_use  = at_speed_reg ? cfg_reg.cls_run
                                        : cfg_reg.cls_start;
   wire  [4:0]  cls_eff  = (cls_use < mtop_pkg::CLASS_MIN) ?
                           mtop_pkg::CLASS_MIN : cls_use;
   wire  [23:0] rated    = 24'(({8'h0, cfg_reg.fla} * {16'h0, cfg_reg.sf})
                           / 24'd100);
   wire  [47:0] rated_sq = {24'h0, rated} * {24'h0, rated};
   wire  [31:0] cur_sq   = {16'h0, MOTOR_CURRENT_I} *
                           {16'h0, MOTOR_CURRENT_I};
   wire         over     = ({16'h0, cur_sq} > rated_sq);
   wire  [63:0] heat     = {16'h0, {16'h0, cur_sq} - rated_sq} *
                           {32'h0, mtop_pkg::THERM_GAIN};
   wire  [63:0] denom    = {32'h0, {16'h0, cfg_reg.fla} *
                           {16'h0, cfg_reg.fla}} * {59'h0, cls_eff};
   wire  [63:0] loss     = fla_zero ? 64'h0 : heat / denom;
   wire  [31:0] room     = mtop_pkg::THERM_FULL - acc_reg;
   wire  [31:0] cool     = (room >> mtop_pkg::COOL_SHIFT) +
                           {31'h0, (room != 32'h0)};
   wire  [39:0] pct_prod = {8'h0, acc_reg} * 40'd100;
   wire  [7:0]  pct      = pct_prod[mtop_pkg::THERM_SHIFT +: 8];

   always_comb begin
      acc_next = acc_reg;
      if (NV_RESTORE_I) begin
         acc_next = (NV_VALUE_I > mtop_pkg::THERM_FULL) ?
                    mtop_pkg::THERM_FULL : NV_VALUE_I;
      end else if (tick) begin
         if (over && !mode_off && !fla_zero) begin
            acc_next = (loss >= {32'h0, acc_reg}) ? 32'h0
                     : acc_reg - loss[31:0];
         end else begin
            acc_next = acc_reg + cool;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         acc_reg    <= mtop_pkg::THERM_FULL;
         NV_STORE_O <= 1'b0;
      end else begin
         acc_reg    <= acc_next;
         NV_STORE_O <= tick;
      end
   end
   assign NV_VALUE_O = acc_reg;

   // Capacity needed to restart
   logic [7:0] cts;
   logic [7:0] start_pct_reg;
   logic       logged_reg;
   wire        speed_rise = AT_SPEED_I & ~at_speed_reg;
   wire        push = speed_rise & (state_reg == mtop_pkg::ST_RUN) &
                      ~logged_reg;
   wire [7:0]  used = (start_pct_reg > pct) ? start_pct_reg - pct : 8'h0;

   mtop_avg3 u_avg (
      .clk_i  (CLOCK_I),
      .srst_i (SRST_I),
      .push_i (push),
      .val_i  (used),
      .avg_o  (cts)
   );

   wire resettable = (pct >= cts);

   // Trip, inhibit and run control
   logic trip_reg;
   logic inhibit_reg;
   wire  trip_set = (acc_reg == 32'h0) & ~mode_off;
   wire  trip_clr = mode_off | (resettable &
                    (mode_auto | (mode_man & reset_edge)));
   wire  inh_set  = trip_reg & mode_man & reset_edge & ~resettable;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         mtop_pkg::ST_IDLE: begin
            if (run_rise && fla_zero) begin
               state_next = mtop_pkg::ST_MISSING_FULL_LOAD_INDICATION;
            end else if (run_rise && !trip_reg) begin
               state_next = mtop_pkg::ST_RUN;
            end
         end
         mtop_pkg::ST_RUN: begin
            if (!pin_reg[P_RUN] || trip_reg || fla_zero) begin
               state_next = mtop_pkg::ST_IDLE;
            end
         end
         mtop_pkg::ST_MISSING_FULL_LOAD_INDICATION: begin
            if (reset_edge && !fla_zero) begin
               state_next = mtop_pkg::ST_IDLE;
            end
         end
         default: state_next = mtop_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         state_reg    <= mtop_pkg::ST_IDLE;
         trip_reg     <= 1'b0;
         inhibit_reg  <= 1'b0;
         at_speed_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         trip_reg     <= trip_set | (trip_reg & ~trip_clr);
         inhibit_reg  <= inh_set | (inhibit_reg & trip_reg & ~trip_clr);
         at_speed_reg <= AT_SPEED_I & (state_reg == mtop_pkg::ST_RUN);
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         start_pct_reg <= mtop_pkg::PCT_FULL;
         logged_reg    <= 1'b0;
      end else if (state_next == mtop_pkg::ST_RUN &&
                   state_reg != mtop_pkg::ST_RUN) begin
         start_pct_reg <= pct;
         logged_reg    <= 1'b0;
      end else if (push) begin
         logged_reg    <= 1'b1;
      end
   end

   assign FIRE_EN_O       = (state_reg == mtop_pkg::ST_RUN) & ~trip_reg &
                            ~fla_zero;
   assign OL_TRIP_O       = trip_reg;
   assign MISSING_FULL_LOAD_INDICATION_FAULT_O    = (state_reg == mtop_pkg::ST_MISSING_FULL_LOAD_INDICATION);
   assign RESET_INHIBIT_O = inhibit_reg;

   // Overload LED
   logic [31:0] blink_cnt_reg;
   logic        blink_reg;
   logic        led_reg;
   wire  blink_wrap = (blink_cnt_reg == 32'(BLINK_CYC - 1));

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         blink_cnt_reg <= 32'h0;
         blink_reg     <= 1'b0;
         led_reg       <= 1'b0;
      end else begin
         blink_cnt_reg <= blink_wrap ? 32'h0 : blink_cnt_reg + 32'h1;
         blink_reg     <= blink_reg ^ blink_wrap;
         led_reg       <= trip_reg & (~resettable | blink_reg);
      end
   end
   assign OL_LED_O = led_reg;

   // Status screens
   logic [2:0] screen_reg;
   mtop_pkg::mtop_disp_t disp_reg;
   wire [2:0] scr_up = (screen_reg == mtop_pkg::SCREEN_LAST) ? 3'h0
                     : screen_reg + 3'h1;
   wire [2:0] scr_dn = (screen_reg == 3'h0) ? mtop_pkg::SCREEN_LAST
                     : screen_reg - 3'h1;
   wire [7:0] pct_lo = (pct >= mtop_pkg::PCT_FULL) ?
                       pct - mtop_pkg::PCT_FULL : pct;

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         screen_reg <= 3'h0;
         disp_reg   <= '0;
      end else begin
         if (pin_rise[P_UP]) begin
            screen_reg <= scr_up;
         end else if (pin_rise[P_DN]) begin
            screen_reg <= scr_dn;
         end
         if (screen_reg == mtop_pkg::SCREEN_THERM) begin
            disp_reg.letter <= mtop_pkg::LETTER_H;
            disp_reg.d2     <= {3'h0, pct >= mtop_pkg::PCT_FULL};
            disp_reg.d1     <= 4'(pct_lo / 8'd10);
            disp_reg.d0     <= 4'(pct_lo % 8'd10);
         end else begin
            disp_reg <= {mtop_pkg::LETTER_NONE, 12'h000};
         end
      end
   end
   assign SCREEN_O = screen_reg;
   assign DISP_O   = disp_reg;

   // Settings port
   wire [31:0] status_word = {26'h0, at_speed_reg,
      state_reg == mtop_pkg::ST_RUN, inhibit_reg, MISSING_FULL_LOAD_INDICATION_FAULT_O,
      resettable, trip_reg};
   logic [31:0] rd_mux;

   always_comb begin
      unique case (REG_ADDR_I)
         mtop_pkg::ADDR_FLA:     rd_mux = {16'h0, cfg_reg.fla};
         mtop_pkg::ADDR_SF:      rd_mux = {24'h0, cfg_reg.sf};
         mtop_pkg::ADDR_CLS_ST:  rd_mux = {27'h0, cfg_reg.cls_start};
         mtop_pkg::ADDR_CLS_RUN: rd_mux = {27'h0, cfg_reg.cls_run};
         mtop_pkg::ADDR_MODE:    rd_mux = {30'h0, cfg_reg.mode};
         mtop_pkg::ADDR_STATUS:  rd_mux = status_word;
         mtop_pkg::ADDR_PCT:     rd_mux = {24'h0, pct};
         mtop_pkg::ADDR_CTS:     rd_mux = {24'h0, cts};
         default:                rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         cfg_reg     <= {mtop_pkg::RST_FLA, mtop_pkg::RST_SF,
                         mtop_pkg::RST_CLASS, mtop_pkg::RST_CLASS,
                         mtop_pkg::MODE_MANUAL};
         REG_RDATA_O <= 32'h0;
      end else begin
         REG_RDATA_O <= REG_RD_I ? rd_mux : 32'h0;
         if (REG_WR_I) begin
            unique case (REG_ADDR_I)
               mtop_pkg::ADDR_FLA:     cfg_reg.fla <= REG_WDATA_I[15:0];
               mtop_pkg::ADDR_SF:      cfg_reg.sf <= REG_WDATA_I[7:0];
               mtop_pkg::ADDR_CLS_ST:  cfg_reg.cls_start <= REG_WDATA_I[4:0];
               mtop_pkg::ADDR_CLS_RUN: cfg_reg.cls_run <= REG_WDATA_I[4:0];
               mtop_pkg::ADDR_MODE:    cfg_reg.mode <= REG_WDATA_I[1:0];
               default: ;
            endcase
         end
      end
   end

   // Checks
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);

   sequence trip_locked_s;
      trip_reg && !resettable;
   endsequence

   sequence early_reset_s;
      trip_reg && mode_man && !resettable ##0 reset_edge;
   endsequence

   missing_full_load_indication_fault_a: assert property (
      state_reg == mtop_pkg::ST_IDLE && run_rise && fla_zero
      |=> MISSING_FULL_LOAD_INDICATION_FAULT_O && !FIRE_EN_O)
      else $error("start without FLA did not fault");
   zero_trip_a: assert property (
      acc_reg == 32'h0 && !mode_off |=> OL_TRIP_O ##0 !FIRE_EN_O)
      else $error("empty thermal register did not trip");
   trip_free_a: assert property (
      pin_reg[P_RS] && trip_set |=> trip_reg)
      else $error("held reset key blocked a trip");
   manual_hold_a: assert property (
      trip_reg && mode_man && !reset_edge && !NV_RESTORE_I
      |=> trip_reg)
      else $error("manual trip cleared without reset key");
   early_inhibit_a: assert property (
      early_reset_s |=> RESET_INHIBIT_O && OL_TRIP_O)
      else $error("early reset not inhibited");
   led_solid_a: assert property (
      trip_locked_s |=> OL_LED_O)
      else $error("overload LED not lit while locked");
   auto_clear_a: assert property (
      mode_auto && trip_reg && resettable && acc_reg != 32'h0
      |=> !trip_reg)
      else $error("auto mode did not clear trip");
   therm_screen_a: assert property (
      screen_reg == mtop_pkg::SCREEN_THERM
      |=> DISP_O.letter == mtop_pkg::LETTER_H)
      else $error("thermal screen letter wrong");
   screen_wrap_a: assert property (
      pin_rise[P_UP] && screen_reg == mtop_pkg::SCREEN_LAST
      |=> screen_reg == 3'h0)
      else $error("screens did not wrap");
   cap_bound_a: assert property (
      acc_reg <= mtop_pkg::THERM_FULL && pct <= mtop_pkg::PCT_FULL)
      else $error("thermal register above full");
   heat_drop_a: assert property (
      tick && over && !mode_off && !fla_zero && !NV_RESTORE_I
      |=> acc_reg <= $past(acc_reg))
      else $error("capacity rose under overload");
endmodule

// [tb/mtop_motor_model.sv]
/*
 Motor and current sensor model: current follows the commanded load
 only while firing is enabled; at-speed rises after a fixed spin-up.
 Assumes the overload block's clock and reset.
*/
`timescale 1ns/10ps
module mtop_motor_model #(
   parameter int unsigned SPIN_CYC = 20
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        fire_en_i,
   input  wire logic [15:0] load_i,
   output logic      [15:0] current_o,
   output logic             at_speed_o
);
   logic [7:0] spin_reg;

   // No firing means no motor current and no speed
   always_ff @(posedge clk_i) begin
      if (srst_i || !fire_en_i) begin
         spin_reg   <= 8'h00;
         current_o  <= 16'h0000;
         at_speed_o <= 1'b0;
      end else begin
         current_o  <= load_i;
         if (spin_reg != 8'(SPIN_CYC)) begin
            spin_reg <= spin_reg + 8'h01;
         end
         at_speed_o <= (spin_reg == 8'(SPIN_CYC));
      end
   end
endmodule

// [tb/mtop_overload_tb.sv]
/*
 Self-checking bench of the thermal overload block with a motor model.
 Assumes short tick and blink counts set through the parameters.
*/
`timescale 1ns/10ps
module mtop_overload_tb;
   logic        clk, srst, wr, rd, kup, kdn, krst, run, nvr;
   logic        at_spd, nvs, fire, trip, led, missing_full_load_indication, inh;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, nvv, nv_o, v;
   logic [15:0] cur, load, lfsr;
   logic [2:0]  screen;
   mtop_pkg::mtop_disp_t disp;
   int          failures, comparisons, cyc, chg;
   logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18,
                           8'h1c, 8'h20};
   logic [31:0] rv [8] = '{32'h0, 32'h64, 32'ha, 32'ha, 32'h0, 32'h64,
                           32'h28, 32'h0};

   mtop_overload #(.TICK_CYC(50), .BLINK_CYC(8)) i_dut (
      .CLOCK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .MOTOR_CURRENT_I(cur), .AT_SPEED_I(at_spd),
      .KEY_UP_I(kup), .KEY_DOWN_I(kdn), .KEY_RESET_I(krst),
      .RUN_CMD_I(run), .NV_RESTORE_I(nvr), .NV_VALUE_I(nvv),
      .NV_VALUE_O(nv_o), .NV_STORE_O(nvs), .FIRE_EN_O(fire),
      .OL_TRIP_O(trip), .OL_LED_O(led), .MISSING_FULL_LOAD_INDICATION_FAULT_O(missing_full_load_indication),
      .RESET_INHIBIT_O(inh), .SCREEN_O(screen), .DISP_O(disp));

   mtop_motor_model i_motor (
      .clk_i(clk), .srst_i(srst), .fire_en_i(fire), .load_i(load),
      .current_o(cur), .at_speed_o(at_spd));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Cycles to trip from full at load 100, FLA 4, SF 100, class 5
   function automatic int exp_trip();
      longint d;
      d = (longint'(10000) - 16) * longint'(mtop_pkg::THERM_GAIN) / 80;
      return int'((longint'(mtop_pkg::THERM_FULL) + d - 1) / d) * 50;
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask

   task automatic key(input logic [2:0] k);
      {kup, kdn, krst} <= k;
      tick(8);
      {kup, kdn, krst} <= 3'b000;
      tick(8);
   endtask

   task automatic restore_full();
      nvv <= 32'hffff_ffff;
      nvr <= 1'b1;
      @(posedge clk);
      nvr <= 1'b0;
      tick(5);
   endtask

   task automatic heat();
      int n;
      run <= 1'b1;
      tick(10);
      check({31'h0, fire}, 32'h1);
      load <= 16'h0064;
      for (n = 0; n < 20000 && trip !== 1'b1; n++) begin
         @(posedge clk);
         if (n == 5000) check({31'h0, nv_o < 32'h4000_0000}, 32'h1);
      end
      cyc = n;
      check({31'h0, trip}, 32'h1);
      check({31'h0, (cyc > exp_trip() - 200) && (cyc < exp_trip() + 200)},
            32'h1);
      tick(2);
      check({31'h0, fire}, 32'h0);
      load <= 16'h0000;
      run  <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      #(4 * 80000);
      failures++;
      report_and_stop();
   end

   initial begin
      {srst, wr, rd, kup, kdn, krst, run, nvr} = 8'h80;
      addr = 8'h00;
      wdata = 32'h0;
      nvv = 32'h0;
      load = 16'h0;
      lfsr = 16'hb945;
      failures = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd_reg(ra[i], v);
         check(v, rv[i]);
      end
      check(nv_o, 32'h4000_0000);
      $display("test reset values done");
      run <= 1'b1;
      tick(10);
      check({31'h0, missing_full_load_indication}, 32'h1);
      check({31'h0, fire}, 32'h0);
      run <= 1'b0;
      wr_reg(mtop_pkg::ADDR_FLA, 32'h4);
      key(3'b001);
      check({31'h0, missing_full_load_indication}, 32'h0);
      $display("test missing current done");
      repeat (4) key(3'b100);
      check({29'h0, screen}, 32'h4);
      check({12'h0, disp}, 32'h48100);
      repeat (2) key(3'b100);
      check({29'h0, screen}, 32'h0);
      repeat (2) key(3'b010);
      check({29'h0, screen}, 32'h4);
      $display("test screens done");
      wr_reg(mtop_pkg::ADDR_CLS_ST, 32'h5);
      wr_reg(mtop_pkg::ADDR_CLS_RUN, 32'h5);
      run <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         lfsr = lfsr_next(lfsr);
         load <= {14'h0, lfsr[1:0]};
         tick(60);
      end
      rd_reg(mtop_pkg::ADDR_PCT, v);
      check(v, 32'h64);
      check({31'h0, fire}, 32'h1);
      rd_reg(mtop_pkg::ADDR_STATUS, v);
      check(v, 32'h32);
      run <= 1'b0;
      load <= 16'h0;
      tick(10);
      $display("test below rating done");
      krst <= 1'b1;
      heat();
      krst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         tick(10);
         check({31'h0, led}, 32'h1);
      end
      key(3'b001);
      check({30'h0, inh, trip}, 32'h3);
      rd_reg(mtop_pkg::ADDR_STATUS, v);
      check(v, 32'h09);
      restore_full();
      check(nv_o, 32'h4000_0000);
      chg = 0;
      cyc = 0;
      for (int i = 0; i < 100; i++) begin
         v[0] = led;
         @(posedge clk);
         if (led !== v[0]) chg++;
         if (nvs === 1'b1) cyc++;
      end
      check({31'h0, chg > 3}, 32'h1);
      check(cyc, 32'h2);
      key(3'b001);
      check({30'h0, inh, trip}, 32'h0);
      $display("test manual reset done");
      wr_reg(mtop_pkg::ADDR_MODE, 32'h1);
      heat();
      restore_full();
      tick(20);
      check({31'h0, trip}, 32'h0);
      run <= 1'b1;
      tick(10);
      check({31'h0, fire}, 32'h1);
      run <= 1'b0;
      tick(5);
      $display("test auto reset done");
      wr_reg(mtop_pkg::ADDR_MODE, 32'h2);
      run <= 1'b1;
      load <= 16'h0064;
      tick(3000);
      check({31'h0, trip}, 32'h0);
      rd_reg(mtop_pkg::ADDR_PCT, v);
      check(v, 32'h64);
      $display("test protection off done");
      report_and_stop();
   end
endmodule
